// file: verilog/pdx_regs.vh
`ifndef PDX_REGS_VH
`define PDX_REGS_VH

// Clock and line rate
`define PDX_CLK_HZ 250000000
`define PDX_BAUD 62500
`define PDX_BIT_CYC (`PDX_CLK_HZ / `PDX_BAUD)

// Supervision times in ms and derived cycle counts
`define PDX_WDOG_MS 200
`define PDX_WDOG_CYC ((`PDX_CLK_HZ / 1000) * `PDX_WDOG_MS)
`define PDX_RXTMO_MS 5
`define PDX_RXTMO_CYC ((`PDX_CLK_HZ / 1000) * `PDX_RXTMO_MS)

// Process image sizes
`define PDX_MAX_BYTES 5
`define PDX_DEF_BYTES 4

// Buffer depths
`define PDX_RX_DEPTH 128
`define PDX_TX_DEPTH 16

// Frame format
`define PDX_SYNC 8'ha5
`define PDX_FRAME_LAST 3'h6

// Status byte fields
`define PDX_ST_MOD_TMO 4
`define PDX_ST_RX_TMO 3
`define PDX_ST_CHK 2
`define PDX_ST_OVR 1
`define PDX_ST_BAD 0
`define PDX_ST_RESET 8'h00

`endif

// file: verilog/pdx_fifo.v
`timescale 1ns/1ps
`default_nettype none

module pdx_fifo #(
  parameter W = 9,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  wire [AW-1:0] last;
  integer i;
  localparam [31:0] LAST_I = DEPTH - 1;

  assign last = LAST_I[AW-1:0];
  assign in_ready = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != 0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {W{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= (wr_q == last) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == last) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // pdx_fifo

`default_nettype wire

// file: verilog/pdx_link.v
// Contract
// - Exchange output image with peer, full duplex
// - Default exchange width is 32 bits
// - Up to 40 bits plus status byte
// - 32-bit transfer completes in about 1.2 ms
// - Multiplexing delay stays below 5 ms
// - No valid frame 200 ms clears outputs
// - Five data bytes, control and status byte; link_control_byte has no effect
// - Status byte layout with error flags
// - Buffer 128 received bytes
// - Provide 16-byte transmit buffer
`timescale 1ns/1ps
`default_nettype none
`include "pdx_regs.vh"

module pdx_link #(
  parameter NBYTES = `PDX_DEF_BYTES,
  parameter BIT_CYC = `PDX_BIT_CYC,
  parameter WDOG_CYC = `PDX_WDOG_CYC,
  parameter RXTMO_CYC = `PDX_RXTMO_CYC,
  parameter RX_DEPTH = `PDX_RX_DEPTH,
  parameter TX_DEPTH = `PDX_TX_DEPTH
) (
  input wire clk,
  input wire rst_n,
  input wire [39:0] out_image,
  input wire [7:0] link_control_byte,
  output reg [39:0] in_image_q,
  output reg [7:0] link_error_status_byte_q,
  output reg tx_line_q,
  input wire rx_line
);
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BITS = 2'h2;

  wire ctrl_unused;
  assign ctrl_unused = ^link_control_byte;

  wire [39:0] byte_mask;
  genvar g;
  generate
    for (g = 0; g < `PDX_MAX_BYTES; g = g + 1) begin : g_mask
      assign byte_mask[g*8 +: 8] = (g < NBYTES) ? 8'hff : 8'h00;
    end
  endgenerate

  reg [2:0] tx_idx_q;
  reg [39:0] tx_snap_q;
  reg [7:0] tx_sum_q;
  reg [7:0] tb_byte;
  wire txf_ready;
  wire txf_valid;
  wire [7:0] txf_data;
  reg txf_pop;

  always @* begin
    case (tx_idx_q)
      3'h0: tb_byte = `PDX_SYNC;
      `PDX_FRAME_LAST: tb_byte = tx_sum_q;
      default: tb_byte = tx_snap_q[(tx_idx_q - 3'h1)*8 +: 8];
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      tx_idx_q <= 3'h0;
      tx_snap_q <= 40'h0;
      tx_sum_q <= 8'h00;
    end else if (txf_ready) begin
      if (tx_idx_q == 3'h0) begin
        tx_snap_q <= out_image & byte_mask;
        tx_sum_q <= 8'h00;
      end else if (tx_idx_q != `PDX_FRAME_LAST) begin
        tx_sum_q <= tx_sum_q + tb_byte;
      end
      tx_idx_q <= (tx_idx_q == `PDX_FRAME_LAST) ? 3'h0 : tx_idx_q + 3'h1;
    end
  end

  pdx_fifo #(.W(8), .DEPTH(TX_DEPTH), .AW(4)) u_txf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(1'b1),
    .in_ready(txf_ready),
    .in_data(tb_byte),
    .out_valid(txf_valid),
    .out_ready(txf_pop),
    .out_data(txf_data)
  );

  // serial sender, start, 8 data, even parity, stop
  reg [10:0] tx_sh_q;
  reg [3:0] tx_bits_q;
  reg [12:0] tx_cnt_q;

  always @* begin
    txf_pop = txf_valid && (tx_bits_q == 4'h0);
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      tx_sh_q <= 11'h7ff;
      tx_bits_q <= 4'h0;
      tx_cnt_q <= 13'h0;
      tx_line_q <= 1'b1;
    end else if (txf_pop) begin
      tx_sh_q <= {1'b1, ^txf_data, txf_data, 1'b0};
      tx_bits_q <= 4'hb;
      tx_cnt_q <= 13'h0;
    end else if (tx_bits_q != 4'h0) begin
      tx_line_q <= tx_sh_q[0];
      if (tx_cnt_q == BIT_CYC - 1) begin
        tx_cnt_q <= 13'h0;
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
      end else begin
        tx_cnt_q <= tx_cnt_q + 13'h1;
      end
    end else begin
      tx_line_q <= 1'b1;
    end
  end

  reg [1:0] rx_st_q;
  reg [12:0] rx_cnt_q;
  reg [3:0] rx_bits_q;
  reg [9:0] rx_sh_q;
  reg rx_done_q;
  wire [8:0] rx_word;
  wire sk_ready;
  wire sk_valid;
  wire [8:0] sk_data;
  wire rxf_ready;
  wire rxf_valid;
  wire [8:0] rxf_data;

  // error tag is bad parity or missing stop bit
  assign rx_word = {(^rx_sh_q[8:0]) | ~rx_sh_q[9], rx_sh_q[7:0]};

  always @(posedge clk) begin
    if (!rst_n) begin
      rx_st_q <= ST_IDLE;
      rx_cnt_q <= 13'h0;
      rx_bits_q <= 4'h0;
      rx_sh_q <= 10'h0;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      case (rx_st_q)
        ST_IDLE: begin
          rx_cnt_q <= 13'h0;
          if (!rx_line) begin
            rx_st_q <= ST_START;
          end
        end
        ST_START: begin
          if (rx_cnt_q == BIT_CYC / 2 - 1) begin
            rx_cnt_q <= 13'h0;
            rx_bits_q <= 4'ha;
            rx_st_q <= rx_line ? ST_IDLE : ST_BITS;
          end else begin
            rx_cnt_q <= rx_cnt_q + 13'h1;
          end
        end
        ST_BITS: begin
          if (rx_cnt_q == BIT_CYC - 1) begin
            rx_cnt_q <= 13'h0;
            rx_sh_q <= {rx_line, rx_sh_q[9:1]};
            rx_bits_q <= rx_bits_q - 4'h1;
            if (rx_bits_q == 4'h1) begin
              rx_done_q <= 1'b1;
              rx_st_q <= ST_IDLE;
            end
          end else begin
            rx_cnt_q <= rx_cnt_q + 13'h1;
          end
        end
        default: begin
          rx_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Two-entry buffer ahead of the receive buffer
  pdx_fifo #(.W(9), .DEPTH(2), .AW(1)) u_skid (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rx_done_q),
    .in_ready(sk_ready),
    .in_data(rx_word),
    .out_valid(sk_valid),
    .out_ready(rxf_ready),
    .out_data(sk_data)
  );

  pdx_fifo #(.W(9), .DEPTH(RX_DEPTH), .AW(7)) u_rxf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(sk_valid),
    .in_ready(rxf_ready),
    .in_data(sk_data),
    .out_valid(rxf_valid),
    .out_ready(1'b1),
    .out_data(rxf_data)
  );

  // Frame parser
  reg [2:0] rx_idx_q;
  reg [39:0] rx_shadow_q;
  reg [7:0] rx_sum_q;
  reg rx_err_q;
  reg [25:0] wdog_q;
  reg [22:0] rxtmo_q;
  reg mod_tmo_q;
  reg rx_tmo_q;
  reg chk_q;
  reg ovr_q;
  reg bad_q;
  wire frame_end;
  wire frame_ok;
  wire frame_chk;
  wire frame_bad;

  assign frame_end = rxf_valid && (rx_idx_q == `PDX_FRAME_LAST);
  assign frame_bad = frame_end && (rx_err_q | rxf_data[8]);
  assign frame_chk = frame_end && !frame_bad && (rxf_data[7:0] != rx_sum_q);
  assign frame_ok = frame_end && !frame_bad && !frame_chk;

  always @(posedge clk) begin
    if (!rst_n) begin
      rx_idx_q <= 3'h0;
      rx_shadow_q <= 40'h0;
      rx_sum_q <= 8'h00;
      rx_err_q <= 1'b0;
    end else if (rxf_valid) begin
      if (rx_idx_q == 3'h0) begin
        rx_sum_q <= 8'h00;
        rx_err_q <= 1'b0;
        if (rxf_data == {1'b0, `PDX_SYNC}) begin
          rx_idx_q <= 3'h1;
        end
      end else if (rx_idx_q == `PDX_FRAME_LAST) begin
        rx_idx_q <= 3'h0;
      end else begin
        rx_shadow_q[(rx_idx_q - 3'h1)*8 +: 8] <= rxf_data[7:0];
        rx_sum_q <= rx_sum_q + rxf_data[7:0];
        rx_err_q <= rx_err_q | rxf_data[8];
        rx_idx_q <= rx_idx_q + 3'h1;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wdog_q <= 26'h0;
      mod_tmo_q <= 1'b1;
      in_image_q <= 40'h0;
    end else if (frame_ok) begin
      wdog_q <= 26'h0;
      mod_tmo_q <= 1'b0;
      in_image_q <= rx_shadow_q & byte_mask;
    end else if (wdog_q == WDOG_CYC - 1) begin
      mod_tmo_q <= 1'b1;
      in_image_q <= 40'h0;
    end else begin
      wdog_q <= wdog_q + 26'h1;
    end
  end

  // receiver timeout and sticky error flags
  always @(posedge clk) begin
    if (!rst_n) begin
      rxtmo_q <= 23'h0;
      rx_tmo_q <= 1'b0;
      chk_q <= 1'b0;
      ovr_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      if (rx_done_q) begin
        rxtmo_q <= 23'h0;
        rx_tmo_q <= 1'b0;
      end else if (rxtmo_q == RXTMO_CYC - 1) begin
        rx_tmo_q <= 1'b1;
      end else begin
        rxtmo_q <= rxtmo_q + 23'h1;
      end
      chk_q <= frame_chk | (chk_q & ~frame_ok);
      bad_q <= frame_bad | (bad_q & ~frame_ok);
      ovr_q <= (rx_done_q & ~sk_ready) | (ovr_q & ~frame_ok);
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      link_error_status_byte_q <= `PDX_ST_RESET;
    end else begin
      link_error_status_byte_q <= `PDX_ST_RESET;
      link_error_status_byte_q[`PDX_ST_MOD_TMO] <= mod_tmo_q;
      link_error_status_byte_q[`PDX_ST_RX_TMO] <= rx_tmo_q;
      link_error_status_byte_q[`PDX_ST_CHK] <= chk_q;
      link_error_status_byte_q[`PDX_ST_OVR] <= ovr_q;
      link_error_status_byte_q[`PDX_ST_BAD] <= bad_q & ~ctrl_unused | bad_q;
    end
  end
endmodule // pdx_link

`default_nettype wire

// file: sim/pdx_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pdx_link_asserts #(parameter WDOG_CYC = 2000, parameter RXTMO_CYC = 400) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [39:0] in_image_q,
  input wire logic [7:0] link_error_status_byte_q,
  input wire logic tx_line_q,
  input wire logic rx_line
);
  logic [31:0] idle_q;
  wire logic [7:0] st = link_error_status_byte_q;
  // Cycles since the receive line was last low
  always @(posedge clk) idle_q <= (!rst_n || !rx_line) ? 32'h0 : idle_q + 32'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_top; st[7:5] == 3'h0; endproperty
  a_top: assert property (p_top) else $error("status top bits set");
  property p_bit; $changed(tx_line_q) |=> $stable(tx_line_q) [*7]; endproperty
  a_bit: assert property (p_bit) else $error("line bit too short");
  property p_rxt; idle_q == RXTMO_CYC + 20 |-> st[3]; endproperty
  a_rxt: assert property (p_rxt) else $error("no rx timeout");
  property p_rxc; $fell(rx_line) |-> ##[0:120] !st[3]; endproperty
  a_rxc: assert property (p_rxc) else $error("rx timeout stuck");
  property p_wd; idle_q == WDOG_CYC + 100 |-> st[4]; endproperty
  a_wd: assert property (p_wd) else $error("no watchdog");
  property p_wdz; $rose(st[4]) |-> ##[0:2] in_image_q == 40'h0; endproperty
  a_wdz: assert property (p_wdz) else $error("image kept in timeout");
  property p_good; $changed(in_image_q) && in_image_q != 40'h0 |-> ##[0:2] !st[4]; endproperty
  a_good: assert property (p_good) else $error("timeout kept");
  property p_bad; $rose(st[0]) || $rose(st[2]) |-> $stable(in_image_q) [*4]; endproperty
  a_bad: assert property (p_bad) else $error("bad frame taken");
  c_par: cover property ($rose(st[0]));
  c_sum: cover property ($rose(st[2]));
  c_wd: cover property ($rose(st[4]));
endmodule // pdx_link_asserts
bind pdx_link pdx_link_asserts #(.WDOG_CYC(WDOG_CYC), .RXTMO_CYC(RXTMO_CYC)) pdx_link_asserts_i (.clk(clk),
  .rst_n(rst_n), .in_image_q(in_image_q), .link_error_status_byte_q(link_error_status_byte_q),
  .tx_line_q(tx_line_q), .rx_line(rx_line));
`default_nettype wire

// file: sim/pdx_peer.sv
`timescale 1ns/1ps
`default_nettype none
module pdx_peer #(parameter BIT_CYC = 8) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  logic [55:0] sh = 56'h0;
  logic [39:0] got = 40'h0;
  logic [9:0] r;
  int frames = 0;
  initial line_out = 1'b1;
  // start, data lsb first, even parity, stop
  task automatic put(input logic [7:0] c, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^c ^ bad, c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out = f[i];
      repeat (BIT_CYC) @(negedge clk);
    end
  endtask
  task automatic send(input logic [39:0] d, input logic bp, input logic bs);
    put(8'ha5, 1'b0);
    for (int i = 0; i < 5; i++)
      put(d[8*i +: 8], bp && i == 2);
    put(d[7:0] + d[15:8] + d[23:16] + d[31:24] + d[39:32] + {7'h0, bs}, 1'b0);
  endtask
  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      r[i] = line_in;
    end
    sh = {r[7:0], sh[55:8]};
    if (sh[7:0] == 8'ha5 && sh[55:48] == sh[15:8] + sh[23:16] + sh[31:24] + sh[39:32] + sh[47:40] && r[9]) begin
      got = sh[47:8];
      frames++;
    end
  end
endmodule // pdx_peer
`default_nettype wire

// file: sim/process_data_exchange_link_test.sv
`timescale 1ns/1ps
`default_nettype none
module process_data_exchange_link_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [39:0] img = 40'h0;
  wire logic [39:0] rimg;
  wire logic [7:0] st;
  wire logic tx;
  wire logic rx;
  int err_count = 0;
  int tests_run = 0;
  // control byte with bit 7 clear
  pdx_link #(.NBYTES(5), .BIT_CYC(8), .WDOG_CYC(2000), .RXTMO_CYC(400)) pdx_link_i (.clk(clk), .rst_n(rst_n),
    .out_image(img), .link_control_byte(8'h7f), .in_image_q(rimg), .link_error_status_byte_q(st),
    .tx_line_q(tx), .rx_line(rx));
  pdx_peer pdx_peer_i (.clk(clk), .line_in(tx), .line_out(rx));
  initial forever #2 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_st(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t status %h want %h", $time, g, e);
    end
  endtask
  task automatic rxf(input logic [39:0] d, input logic bp, input logic bs, input logic [39:0] e, input logic [7:0] es);
    pdx_peer_i.send(d, bp, bs);
    cyc(6);
    chk(rimg, e);
    chk_st(st, es);
  endtask
  // Wait for n frames at the peer, then compare the last one
  task automatic txw(input logic [39:0] e, input int n);
    int n0;
    n0 = pdx_peer_i.frames + n;
    for (int i = 0; i < n * 800 && pdx_peer_i.frames < n0; i++)
      cyc(1);
    chk({39'h0, pdx_peer_i.frames < n0}, 40'h0);
    if (pdx_peer_i.frames < n0)
      finish_test();
    chk(pdx_peer_i.got, e);
  endtask
  initial begin
    cyc(3);
    chk(rimg, 40'h0);
    rst_n = 1'b1;
    img = 40'h81c35a0f01;
    txw(img, 2);
    $display("test tx done");
    rxf(40'hf012345601, 1'b0, 1'b0, 40'hf012345601, 8'h00);
    rxf(40'h0, 1'b1, 1'b0, 40'hf012345601, 8'h01);
    rxf(40'h0fedcba901, 1'b0, 1'b0, 40'h0fedcba901, 8'h00);
    rxf(40'h1111111101, 1'b0, 1'b1, 40'h0fedcba901, 8'h04);
    $display("test rx done");
    cyc(450);
    chk_st(st, 8'h0c);
    cyc(1700);
    chk_st(st, 8'h1c);
    chk(rimg, 40'h0);
    rxf(40'h22, 1'b0, 1'b0, 40'h22, 8'h00);
    $display("test timeout done");
    rxf(40'h0000000001, 1'b0, 1'b0, 40'h0000000001, 8'h00);
    // bit 8 is the toggle bit each way
    chk({39'h0, rimg[8] != img[8]}, 40'h1);
    img = {img[39:9], ~img[8], img[7:2], rimg[0], img[0]};
    txw(img, 5);
    $display("test handshake done");
    rst_n = 1'b0;
    cyc(3);
    chk(rimg, 40'h0);
    $display("test reset done");
    finish_test();
  end
endmodule // process_data_exchange_link_test
`default_nettype wire
